// file: smc_controller_monitor.sv
/*
  Concurrent checks on the sleep-mode controller ports.
  Assumes one clk_sys domain and an active-low nrst.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_controller_monitor
  import smc_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       lowPowerArm,
  input wire logic [2:0] powerStateSelect,
  input wire logic       sleepExec,
  input wire logic       crystalSelected,
  input wire logic       converterEnabled,
  input wire logic       wakeReset,
  input wire logic       coreClockEn,
  input wire logic       programMemClockEn,
  input wire logic       peripheralClockEn,
  input wire logic       converterClockEn,
  input wire logic       asyncTimerClockEn,
  input wire logic       mainOscEn,
  input wire logic       brownoutDetectorEn,
  input wire logic       brownoutDozeOff,
  input wire logic       converterStart,
  input wire logic       coreHold,
  input wire logic       resetRequest,
  input wire logic       sleeping
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========================================
  // Entry and clock gating
  entry_armed_a: assert property (
    sleepExec && lowPowerArm && !sleeping && !coreHold && !$past(coreHold) |=> sleeping)
    else $error("armed sleep not entered");
  unarmed_ignore_a: assert property (
    sleepExec && !lowPowerArm && !sleeping && !coreHold |=> !sleeping)
    else $error("unarmed sleep entered");
  idle_clocks_a: assert property (
    sleeping && powerStateSelect == MODE_IDLE |-> !coreClockEn && !programMemClockEn
      && peripheralClockEn && converterClockEn)
    else $error("idle clock gating wrong");
  quiet_clocks_a: assert property (
    sleeping && powerStateSelect == MODE_QUIET |-> !coreClockEn && !programMemClockEn
      && !peripheralClockEn && converterClockEn)
    else $error("quiet clock gating wrong");
  pdown_clocks_a: assert property (
    sleeping && powerStateSelect == MODE_PDOWN |-> !(coreClockEn || programMemClockEn
      || peripheralClockEn || converterClockEn || asyncTimerClockEn || mainOscEn))
    else $error("power-down clocks running");
  conv_start_a: assert property (
    $rose(sleeping) && converterEnabled && powerStateSelect == MODE_IDLE |-> ##[0:1] converterStart)
    else $error("no conversion start");
  // ==========================================
  // Wake-up sequencing
  idle_hold_a: assert property (
    $fell(sleeping) && coreHold && powerStateSelect == MODE_IDLE |-> coreHold[*5] ##1 !coreHold)
    else $error("idle hold length wrong");
  stby_wake_a: assert property (
    $fell(sleeping) && coreHold && powerStateSelect == MODE_STBY && crystalSelected
      && !brownoutDozeOff |-> ##[1:7] !coreHold)
    else $error("standby wake too slow");
  reset_wake_a: assert property (
    sleeping && wakeReset |=> resetRequest && !sleeping ##1 !resetRequest)
    else $error("reset wake wrong");
  doze_off_a: assert property (
    $rose(sleeping) && brownoutDozeOff && powerStateSelect == MODE_PDOWN |-> !brownoutDetectorEn)
    else $error("detector not switched off");
  det_back_a: assert property (
    $fell(sleeping) |-> brownoutDetectorEn)
    else $error("detector not re-enabled");
  cover property ($fell(sleeping) && coreHold);
  cover property (sleeping && !brownoutDetectorEn);
  cover property (resetRequest);
endmodule
bind smc_sleep_mode_controller smc_controller_monitor smc_controller_monitor_i (
  .clk_sys, .nrst, .lowPowerArm, .powerStateSelect, .sleepExec, .crystalSelected,
  .converterEnabled, .wakeReset, .coreClockEn, .programMemClockEn, .peripheralClockEn,
  .converterClockEn, .asyncTimerClockEn, .mainOscEn, .brownoutDetectorEn,
  .brownoutDozeOff, .converterStart, .coreHold, .resetRequest, .sleeping);
`default_nettype wire

// file: smc_core_model.sv
/*
  Core model: sets the arm bit, then issues a one-cycle sleep instruction.
  Assumes the bench pulses req for one cycle while the core is running.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_core_model (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic req,
  input  wire logic reqArm,
  output var  logic lowPowerArm,
  output var  logic sleepExec
);
  logic pend;
  // ==========================================
  // arm written before sleep instruction
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lowPowerArm <= 1'b0;
      sleepExec   <= 1'b0;
      pend        <= 1'b0;
    end else begin
      lowPowerArm <= req ? reqArm : lowPowerArm;
      pend        <= req;
      sleepExec   <= pend;
    end
  end
endmodule
`default_nettype wire

// file: smc_counter.sv
/*
  Loadable down counter with a done flag.
  Assumes load and count come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_counter #(
  parameter int W = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] loadValue,
  output var  logic         done
);
  typedef struct packed {
    logic [W-1:0] count;
  } smc_cnt_t;
  smc_cnt_t r;
  smc_cnt_t next_r;
  always_comb begin
    next_r = r;
    if (load) begin
      next_r.count = loadValue;
    end else if (r.count != '0) begin
      next_r.count = r.count - 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  // Registered zero only; the sequencer loads from done
  assign done = (r.count == '0);
endmodule
`default_nettype wire

// file: smc_pkg.sv
/*
  Constants, modes and state codes for the sleep-mode controller.
  Assumes a 25 MHz system clock.
*/
`default_nettype none
package smc_pkg;
  // ==========================================
  // Mode select codes
  localparam logic [2:0] MODE_IDLE     = 3'h0;
  localparam logic [2:0] MODE_QUIET    = 3'h1;
  localparam logic [2:0] MODE_PDOWN    = 3'h2;
  localparam logic [2:0] MODE_PSAVE    = 3'h3;
  localparam logic [2:0] MODE_STBY     = 3'h6;
  localparam logic [2:0] MODE_XSTBY    = 3'h7;
  // ==========================================
  // Core control register layout
  localparam int       DOZE_OFF_BIT   = 6;
  localparam logic     DOZE_OFF_RST   = 1'b0;
  localparam int       TIMED_WINDOW   = 4;
  // ==========================================
  // Timing
  localparam int CLK_MHZ        = 25;
  localparam int HOLD_CYCLES    = 4;
  localparam int BOD_WAKE_US    = 60;
  localparam int BOD_WAKE_CYC   = BOD_WAKE_US * CLK_MHZ;
  localparam int STBY_WAKE_CYC  = 6;
  localparam int CNT_W          = 16;
  // ==========================================
  // Controller states
  typedef enum logic [4:0] {
    ST_RUN   = 5'h01,
    ST_SLEEP = 5'h02,
    ST_START = 5'h04,
    ST_HOLD  = 5'h08,
    ST_RESUME= 5'h10
  } smc_state_t;
endpackage
`default_nettype wire

// file: smc_sleep_mode_controller.sv
/*
  Sleep-mode controller: decodes mode and arm bits, gates the clock domains,
  qualifies wake sources, sequences wake delays and the brown-out doze-off.
  Assumes wake sources are synchronous to clk_sys and the core pulses
  sleepExec for one cycle when it executes the sleep instruction.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_sleep_mode_controller
  import smc_pkg::*;
#(
  parameter int unsigned START_DEFAULT = 16384
) (
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic                       lowPowerArm,
  input  wire logic [2:0]                 powerStateSelect,
  input  wire logic                       sleepExec,
  input  wire logic                       crystalSelected,
  input  wire logic [smc_pkg::CNT_W-1:0]  clockSourceFuseDelay,
  input  wire logic                       ctrlWrite,
  input  wire logic [7:0]                 ctrlWriteData,
  input  wire logic                       dozeOffEnable,
  input  wire logic                       converterEnabled,
  input  wire logic                       asyncTimerRunning,
  input  wire logic                       extIrqZeroPending,
  input  wire logic                       extIrqZeroLevelMode,
  input  wire logic                       extIrqOtherPending,
  input  wire logic                       pinChangePending,
  input  wire logic                       twoWireMatchPending,
  input  wire logic                       twoWireIrqPending,
  input  wire logic                       asyncTimerIrqPending,
  input  wire logic                       selfProgramReadyPending,
  input  wire logic                       converterDonePending,
  input  wire logic                       wdogIrqPending,
  input  wire logic                       otherIoIrqPending,
  input  wire logic                       wakeReset,
  output var  logic                       coreClockEn,
  output var  logic                       programMemClockEn,
  output var  logic                       peripheralClockEn,
  output var  logic                       converterClockEn,
  output var  logic                       asyncTimerClockEn,
  output var  logic                       mainOscEn,
  output var  logic                       brownoutDetectorEn,
  output var  logic                       brownoutDozeOff,
  output var  logic                       converterStart,
  output var  logic                       coreHold,
  output var  logic                       resetRequest,
  output var  logic                       sleeping
);
  import smc_pkg::*;

  typedef struct packed {
    smc_state_t       state;
    logic [2:0]       mode;
    logic             dozeOff;
    logic             dozeUsed;
    logic [2:0]       timedCount;
    logic             convStart;
    logic             resetReq;
  } smc_regs_t;

  smc_regs_t r;
  smc_regs_t next_r;
  logic                cntLoad;
  logic [CNT_W-1:0]    cntValue;
  logic                cntDone;
  logic                wakeSrc;
  logic                deepMode;
  logic                stbyMode;
  logic                asyncMode;
  logic                zeroWake;
  logic                entryDeep;
  logic                entryConv;

  // ==========================================
  // Mode classification of the latched mode
  always_comb begin
    deepMode  = 1'b0;
    stbyMode  = 1'b0;
    asyncMode = 1'b0;
    case (r.mode)
      MODE_IDLE: begin
        asyncMode = 1'b1;
      end
      MODE_QUIET: begin
        asyncMode = 1'b1;
      end
      MODE_PSAVE: begin
        deepMode  = 1'b1;
        asyncMode = 1'b1;
      end
      MODE_STBY: begin
        deepMode = 1'b1;
        stbyMode = 1'b1;
      end
      MODE_XSTBY: begin
        deepMode  = 1'b1;
        stbyMode  = 1'b1;
        asyncMode = 1'b1;
      end
      default: begin
        // Power-down and the reserved codes
        deepMode = 1'b1;
      end
    endcase
  end

  // ==========================================
  // Entry decode of the requested mode
  always_comb begin
    entryDeep = 1'b1;
    entryConv = 1'b0;
    case (powerStateSelect)
      MODE_IDLE: begin
        entryDeep = 1'b0;
        entryConv = converterEnabled;
      end
      MODE_QUIET: begin
        entryDeep = 1'b0;
        entryConv = converterEnabled;
      end
      default: begin
        // Reserved codes act as power-down
        entryDeep = 1'b1;
      end
    endcase
  end

  // ==========================================
  // Wake qualification
  always_comb begin
    zeroWake = extIrqZeroPending &&
               ((r.mode == MODE_IDLE) || extIrqZeroLevelMode);
    wakeSrc  = 1'b0;
    case (r.mode)
      MODE_IDLE: begin
        wakeSrc = zeroWake || extIrqOtherPending || pinChangePending ||
                  twoWireMatchPending || twoWireIrqPending ||
                  asyncTimerIrqPending || selfProgramReadyPending ||
                  converterDonePending || wdogIrqPending || otherIoIrqPending;
      end
      MODE_QUIET: begin
        wakeSrc = converterDonePending || wdogIrqPending ||
                  twoWireIrqPending || twoWireMatchPending ||
                  (asyncTimerIrqPending && asyncTimerRunning) ||
                  selfProgramReadyPending || zeroWake ||
                  extIrqOtherPending || pinChangePending;
      end
      MODE_PSAVE, MODE_XSTBY: begin
        wakeSrc = zeroWake || extIrqOtherPending || pinChangePending ||
                  twoWireMatchPending || wdogIrqPending ||
                  (asyncTimerIrqPending && asyncTimerRunning);
      end
      default: begin
        wakeSrc = zeroWake || extIrqOtherPending || pinChangePending ||
                  twoWireMatchPending || wdogIrqPending;
      end
    endcase
  end

  // ==========================================
  // Sequencer
  always_comb begin
    next_r           = r;
    next_r.convStart = 1'b0;
    next_r.resetReq  = 1'b0;
    cntLoad          = 1'b0;
    cntValue         = '0;
    if (dozeOffEnable) begin
      next_r.timedCount = 3'(TIMED_WINDOW);
    end else if (r.timedCount != 3'h0) begin
      next_r.timedCount = r.timedCount - 3'h1;
    end
    if (ctrlWrite && (r.timedCount != 3'h0) && !dozeOffEnable) begin
      next_r.dozeOff    = ctrlWriteData[DOZE_OFF_BIT];
      next_r.timedCount = 3'h0;
    end
    case (r.state)
      ST_RUN: begin
        if (sleepExec && lowPowerArm) begin
          next_r.mode  = powerStateSelect;
          next_r.state = ST_SLEEP;
          next_r.dozeUsed  = r.dozeOff && entryDeep;
          next_r.convStart = entryConv;
        end
      end
      ST_SLEEP: begin
        if (wakeReset) begin
          next_r.resetReq = 1'b1;
          next_r.state    = ST_RUN;
          next_r.dozeUsed = 1'b0;
        end else if (wakeSrc) begin
          next_r.state = ST_START;
          cntLoad      = 1'b1;
          if (r.dozeUsed) begin
            cntValue = CNT_W'(BOD_WAKE_CYC);
          end else if (stbyMode && crystalSelected) begin
            cntValue = CNT_W'(STBY_WAKE_CYC - HOLD_CYCLES);
          end else if (deepMode) begin
            cntValue = clockSourceFuseDelay;
          end else begin
            cntValue = '0;
          end
        end
      end
      ST_START: begin
        if (cntDone) begin
          next_r.dozeUsed = 1'b0;
          next_r.state    = ST_HOLD;
          cntLoad         = 1'b1;
          cntValue        = CNT_W'(HOLD_CYCLES - 1);
        end
      end
      ST_HOLD: begin
        if (cntDone) begin
          next_r.state = ST_RESUME;
        end
      end
      default: begin
        // core state untouched, resume after sleep
        next_r.state = ST_RUN;
      end
    endcase
  end

  // ==========================================
  // Register stage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r.state      <= ST_RUN;
      r.mode       <= MODE_IDLE;
      r.dozeOff    <= DOZE_OFF_RST;
      r.dozeUsed   <= 1'b0;
      r.timedCount <= 3'h0;
      r.convStart  <= 1'b0;
      r.resetReq   <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================
  // Wake delay counter
  smc_counter #(
    .W (CNT_W)
  ) u_wake_count (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .load      (cntLoad),
    .loadValue (cntValue),
    .done      (cntDone)
  );

  // ==========================================
  // Clock gating outputs
  always_comb begin
    sleeping           = (r.state == ST_SLEEP);
    coreClockEn        = (r.state == ST_RUN) || (r.state == ST_RESUME);
    programMemClockEn  = coreClockEn;
    peripheralClockEn  = 1'b1;
    converterClockEn   = 1'b1;
    asyncTimerClockEn  = 1'b1;
    mainOscEn          = 1'b1;
    if (sleeping) begin
      case (r.mode)
        MODE_IDLE: begin
          asyncTimerClockEn = asyncTimerRunning;
        end
        MODE_QUIET: begin
          peripheralClockEn = 1'b0;
          asyncTimerClockEn = asyncTimerRunning;
        end
        default: begin
          peripheralClockEn = 1'b0;
          converterClockEn  = 1'b0;
          asyncTimerClockEn = asyncMode && asyncTimerRunning;
          mainOscEn         = stbyMode && crystalSelected;
        end
      endcase
    end
  end

  // ==========================================
  // Status and pulse outputs
  always_comb begin
    brownoutDetectorEn = !(sleeping && r.dozeUsed);
    brownoutDozeOff    = r.dozeOff;
    converterStart     = r.convStart;
    coreHold           = (r.state == ST_START) || (r.state == ST_HOLD) || sleeping;
    resetRequest       = r.resetReq;
  end
endmodule
`default_nettype wire

// file: tb_sleep_mode_controller.sv
/*
  Self-checking bench for the sleep-mode controller with a core model.
  Assumes package, core model and monitor are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_sleep_mode_controller;
  import smc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        nrst    = 1'b0;
  logic        req     = 1'b0;
  logic        reqArm  = 1'b0;
  logic [2:0]  mode    = 3'h0;
  logic        xtal    = 1'b1;
  logic [15:0] fuse    = 16'h0;
  logic        cw      = 1'b0;
  logic [7:0]  cwData  = 8'h00;
  logic        dze     = 1'b0;
  logic        doze    = 1'b0;
  logic        zeroLvl = 1'b0;
  logic        convEn  = 1'b1;
  logic [10:0] src     = 11'h000;
  logic [7:0]  rnd     = 8'h31;
  logic [2:0]  modes [6] = '{MODE_IDLE, MODE_QUIET, MODE_PDOWN, MODE_PSAVE, MODE_STBY, MODE_XSTBY};
  logic        arm, slpExec, coreClockEn, brownoutDetectorEn, brownoutDozeOff;
  logic        coreHold, resetRequest, sleeping;
  logic        convStart, pmClk, perClk, convClk, asyClk, oscEn;
  int          n_errors = 0;
  int          total_checks = 0;
  always #20 clk_sys = ~clk_sys;
  smc_core_model smc_core_model_i (.clk_sys(clk_sys), .nrst(nrst), .req(req),
    .reqArm(reqArm), .lowPowerArm(arm), .sleepExec(slpExec));
  smc_sleep_mode_controller smc_sleep_mode_controller_i (
    .clk_sys(clk_sys), .nrst(nrst), .lowPowerArm(arm), .powerStateSelect(mode),
    .sleepExec(slpExec), .crystalSelected(xtal), .clockSourceFuseDelay(fuse),
    .ctrlWrite(cw), .ctrlWriteData(cwData), .dozeOffEnable(dze), .converterEnabled(convEn),
    .asyncTimerRunning(rnd[0]), .extIrqZeroPending(src[0]), .extIrqZeroLevelMode(zeroLvl),
    .extIrqOtherPending(src[1]), .pinChangePending(src[2]), .twoWireMatchPending(src[3]),
    .twoWireIrqPending(src[4]), .asyncTimerIrqPending(src[5]),
    .selfProgramReadyPending(src[6]), .converterDonePending(src[7]),
    .wdogIrqPending(src[8]), .otherIoIrqPending(src[9]), .wakeReset(src[10]),
    .coreClockEn(coreClockEn), .programMemClockEn(pmClk), .peripheralClockEn(perClk),
    .converterClockEn(convClk), .asyncTimerClockEn(asyClk), .mainOscEn(oscEn),
    .brownoutDetectorEn(brownoutDetectorEn), .brownoutDozeOff(brownoutDozeOff),
    .converterStart(convStart), .coreHold(coreHold), .resetRequest(resetRequest),
    .sleeping(sleeping));
  // ==========================================
  // Helpers and reference model
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [15:0] expHold();
    int n = 0;
    if (doze && mode >= MODE_PDOWN) n = BOD_WAKE_CYC;
    else if (mode >= MODE_STBY && xtal) n = 2;
    else if (mode >= MODE_PDOWN) n = fuse;
    return 16'(n + 1 + HOLD_CYCLES);
  endfunction
  // Expected {program, peripheral, converter, async, oscillator} enables
  function automatic logic [4:0] expClk(input logic [2:0] m, input logic a);
    logic quiet;
    quiet = (m == MODE_IDLE) || (m == MODE_QUIET);
    if (!a) return 5'h1f;
    return {1'b0, m == MODE_IDLE, quiet,
            rnd[0] && (quiet || m == MODE_PSAVE || m == MODE_XSTBY),
            quiet || (xtal && m >= MODE_STBY)};
  endfunction
  task automatic cycle();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic enter(input logic [2:0] m, input logic a);
    mode = m;
    reqArm = a;
    req = 1'b1;
    cycle();
    req = 1'b0;
    repeat (2) cycle();
    check(convStart, a && convEn && (m == MODE_IDLE || m == MODE_QUIET));
    cycle();
    check(sleeping, a);
    check({pmClk, perClk, convClk, asyClk, oscEn}, expClk(m, a));
  endtask
  task automatic wake(input int s, input logic [15:0] exp);
    int n = 0;
    src[s] = 1'b1;
    cycle();
    src = 11'h000;
    while (coreHold === 1'b1 && sleeping !== 1'b1 && n < 4000) begin
      n++;
      cycle();
    end
    check(16'(n), exp);
    check(sleeping, exp == 16'h0);
    check(brownoutDetectorEn, 1'b1);
    cycle();
  endtask
  task automatic dozeWrite(input logic v);
    dze = 1'b1;
    cycle();
    dze = 1'b0;
    cw = 1'b1;
    cwData = {1'b0, v, 6'h00};
    cycle();
    cw = 1'b0;
    doze = v;
    cycle();
    check(brownoutDozeOff, v);
  endtask
  task automatic final_report();
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  initial begin
    repeat (16) cycle();
    nrst = 1'b1;
    cycle();
    enter(MODE_IDLE, 1'b0);
    foreach (modes[i]) begin
      rnd = lfsr(rnd);
      convEn = rnd[1];
      fuse = {10'h000, rnd[5:0]} + 16'h0001;
      enter(modes[i], 1'b1);
      wake(2, expHold());
    end
    enter(MODE_PDOWN, 1'b1);
    wake(9, 16'h0);
    wake(0, 16'h0);
    zeroLvl = 1'b1;
    wake(0, expHold());
    enter(MODE_QUIET, 1'b1);
    wake(9, 16'h0);
    wake(7, expHold());
    enter(MODE_IDLE, 1'b1);
    wake(9, expHold());
    dozeWrite(1'b1);
    cw = 1'b1;
    cwData = 8'h00;
    cycle();
    cw = 1'b0;
    cycle();
    check(brownoutDozeOff, 1'b1);
    enter(MODE_PDOWN, 1'b1);
    check(brownoutDetectorEn, 1'b0);
    wake(2, expHold());
    dozeWrite(1'b0);
    enter(MODE_PDOWN, 1'b1);
    src[10] = 1'b1;
    cycle();
    src = 11'h000;
    check(resetRequest, 1'b1);
    check(sleeping, 1'b0);
    enter(MODE_PDOWN, 1'b1);
    nrst = 1'b0;
    cycle();
    check(coreClockEn, 1'b1);
    nrst = 1'b1;
    cycle();
    check(sleeping, 1'b0);
    final_report();
  end
  initial begin
    #800000;
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
